// ---- pwo_gate_model.sv ----
// Gate driver model: shutdown pins and resolved pin wires
`timescale 1ns/1ns
`default_nettype none
module pwo_gate_model (
   // Clock and bench command
   input  wire logic       clk_in,
   input  wire logic [3:0] sd_cmd_in,
   // Pins from the block, upper then lower
   input  wire logic [5:0] pin_in,
   input  wire logic [5:0] oen_in,
   // Shutdown lines and wire levels
   output var  logic [3:0] sd_out,
   output var  logic [5:0] wire_out
);
   logic [5:0] last_ff = 6'h00;
   // Shutdown lines follow the bench command
   assign sd_out = sd_cmd_in;
   // A released line shows the inverse of its last driven level
   assign wire_out = (oen_in & ~last_ff) | (~oen_in & pin_in);
   // Remember the level of each driven line
   always @(posedge clk_in) begin
      last_ff <= (oen_in & last_ff) | (~oen_in & pin_in);
   end
endmodule // pwo_gate_model
`default_nettype wire

// ---- pwo_hiz.v ----
// One high-impedance control group: register, shutdown sync and detect flag
`timescale 1ns/1ns
`default_nettype none
`include "pwo_regs.vh"

module pwo_hiz (
   // Clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // Register access
   input  wire       wr_en,
   input  wire [7:0] wdata,
   output wire [7:0] ctrl,
   // Shutdown pin and pin function
   input  wire       shutdown_pin,
   input  wire       func_sel,
   // High-impedance request for the group
   output wire       hiz
);

   reg  [7:0] ctrl_ff;
   reg        flag_ff;
   reg        sync1_ff;
   reg        sync2_ff;
   wire       sd_active;
   wire       set_flag;
   wire       clr_flag;

   // Two-stage synchroniser for the shutdown pin
   always @(posedge clk) begin
      if (!rst_n) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end else begin
         sync1_ff <= shutdown_pin;
         sync2_ff <= sync1_ff;
      end
   end

   // Polarity bit selects the active level of the shutdown pin
   assign sd_active = sync2_ff ^ ~ctrl_ff[`PWO_HIZ_POL];

   // Detect on pin or software trigger, only while enabled
   assign set_flag = ctrl_ff[`PWO_HIZ_EN] &
                     (sd_active | (wr_en & wdata[`PWO_HIZ_TRIG]));
   // Clear in mode 1 only once the pin has returned inactive
   assign clr_flag = wr_en & wdata[`PWO_HIZ_CLR] &
                     ~(ctrl_ff[`PWO_HIZ_MODE] & sd_active);

   // Stored fields and detect flag; set wins over clear
   always @(posedge clk) begin
      if (!rst_n) begin
         ctrl_ff <= `PWO_RST_HIZ;
         flag_ff <= 1'b0;
      end else begin
         if (wr_en) begin
            ctrl_ff <= wdata & `PWO_HIZ_STORE_MASK;
         end
         if (set_flag) begin
            flag_ff <= 1'b1;
         end else if (clr_flag || !ctrl_ff[`PWO_HIZ_EN]) begin
            flag_ff <= 1'b0;
         end
      end
   end

   // Flag read-only, bit 1 reads zero, trigger and clear read zero
   assign ctrl = {ctrl_ff[7:4], 3'b000, flag_ff};
   // Pins float only while enabled, flagged and in timer function
   assign hiz  = ctrl_ff[`PWO_HIZ_EN] & flag_ff & func_sel;

endmodule // pwo_hiz
`default_nettype wire

// ---- pwo_regs.vh ----
// Register map, field positions and reset values of the PWM pin output stage
`ifndef PWO_REGS_VH
`define PWO_REGS_VH

// ---------------------------------------------------------------------------
// Byte addresses of the registers
// ---------------------------------------------------------------------------
`define PWO_ADDR_UPPER_CFG 6'h00
`define PWO_ADDR_LOWER_CFG 6'h04
`define PWO_ADDR_TIMER_CTL 6'h08
`define PWO_ADDR_PIN_STAT  6'h0c
`define PWO_ADDR_HIZ_G0A   6'h10
`define PWO_ADDR_HIZ_G0B   6'h14
`define PWO_ADDR_HIZ_G1A   6'h18
`define PWO_ADDR_HIZ_G1B   6'h1c

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define PWO_RST_UPPER_CFG  8'h00
`define PWO_RST_LOWER_CFG  8'ha8
`define PWO_RST_TIMER_CTL  8'h00
`define PWO_RST_HIZ        8'h00

// ---------------------------------------------------------------------------
// Pin configuration fields: channel m (0..2) level at 3+2m, enable at 2+2m
// ---------------------------------------------------------------------------
`define PWO_CFG_EN_BASE    2
`define PWO_CFG_LVL_BASE   3
`define PWO_CFG_USED_MASK  8'hfc

// ---------------------------------------------------------------------------
// Timer control fields
// ---------------------------------------------------------------------------
`define PWO_TCTL_CE        0
`define PWO_TCTL_FUNC_LO   4
`define PWO_TCTL_MASK      8'hf1

// ---------------------------------------------------------------------------
// High-impedance control fields
// ---------------------------------------------------------------------------
`define PWO_HIZ_EN         7
`define PWO_HIZ_MODE       6
`define PWO_HIZ_EDGE_HI    5
`define PWO_HIZ_POL        4
`define PWO_HIZ_TRIG       3
`define PWO_HIZ_CLR        2
`define PWO_HIZ_ZERO       1
`define PWO_HIZ_FLAG       0
`define PWO_HIZ_STORE_MASK 8'hf0

// ---------------------------------------------------------------------------
// Bus encodings
// ---------------------------------------------------------------------------
`define PWO_HTRANS_NONSEQ  2'h2
`define PWO_HSIZE_HALF     3'h1

`endif

// ---- pwo_top.v ----
// Six-phase PWM pin output stage with high-impedance control, AHB-Lite slave
`timescale 1ns/1ns
`default_nettype none
`include "pwo_regs.vh"

module pwo_top #(
   parameter CHANNELS = 3
) (
   // Clock and reset
   input  wire                SYS_CLK_IN,
   input  wire                RSTN_IN,
   // AHB-Lite slave
   input  wire                HSEL_IN,
   input  wire [31:0]         HADDR_IN,
   input  wire [1:0]          HTRANS_IN,
   input  wire                HWRITE_IN,
   input  wire [2:0]          HSIZE_IN,
   input  wire [31:0]         HWDATA_IN,
   input  wire                HREADY_IN,
   output reg  [31:0]         HRDATA_OUT,
   output reg                 HREADYOUT_OUT,
   output reg                 HRESP_OUT,
   // PWM waveforms from the timer core, same clock
   input  wire [CHANNELS-1:0] PWM_UPPER_IN,
   input  wire [CHANNELS-1:0] PWM_LOWER_IN,
   // Shutdown pins
   input  wire                PHASE_SHUTDOWN_INPUT_IN,
   input  wire                AUX_TIMER_SHUTDOWN_INPUT_IN,
   input  wire                TIMER2_SHUTDOWN_INPUT_IN,
   input  wire                TIMER3_SHUTDOWN_INPUT_IN,
   // Phase pins, enable low while driving
   output reg  [CHANNELS-1:0] UPPER_PHASE_PIN_OUT,
   output reg  [CHANNELS-1:0] UPPER_PHASE_PIN_OEN_OUT,
   output reg  [CHANNELS-1:0] LOWER_PHASE_PIN_OUT,
   output reg  [CHANNELS-1:0] LOWER_PHASE_PIN_OEN_OUT,
   // Timer state and high-impedance request per group
   output reg                 TIMER_COUNT_ENABLE_OUT,
   output reg  [3:0]          HIZ_GROUP_OUT
);

   // ------------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------------

   // Pin level from level bit, enable bit, count enable and waveform
   function drive_level;
      input lvl;
      input en;
      input ce;
      input pwm;
      begin
         if (en && ce) begin
            drive_level = pwm ^ lvl;
         end else begin
            drive_level = lvl;
         end
      end
   endfunction

   // Bit of a config register for channel m: level or enable
   function cfg_bit;
      input [7:0]  cfg;
      input [31:0] m;
      input        want_lvl;
      begin
         if (want_lvl) begin
            cfg_bit = cfg[`PWO_CFG_LVL_BASE + 2 * m];
         end else begin
            cfg_bit = cfg[`PWO_CFG_EN_BASE + 2 * m];
         end
      end
   endfunction

   // ------------------------------------------------------------------------
   // Bus address phase capture
   // ------------------------------------------------------------------------

   reg  [5:0]  addr_ff;
   reg  [2:0]  size_ff;
   reg         wr_ff;
   wire        addr_take;
   wire        low_lane;
   wire [7:0]  wbyte;
   wire        hiz_ok;

   assign addr_take = HSEL_IN & HREADY_IN & (HTRANS_IN == `PWO_HTRANS_NONSEQ);

   // Hold one access; the slave never inserts wait states
   always @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN) begin
         addr_ff       <= 6'h00;
         size_ff       <= 3'h0;
         wr_ff         <= 1'b0;
         HREADYOUT_OUT <= 1'b1;
         HRESP_OUT     <= 1'b0;
      end else begin
         HREADYOUT_OUT <= 1'b1;
         HRESP_OUT     <= 1'b0;
         if (HREADY_IN) begin
            // Writes above the register map are dropped, not aliased
            wr_ff   <= addr_take & HWRITE_IN & (HADDR_IN[31:6] == 26'h0);
            addr_ff <= {HADDR_IN[5:2], 2'b00};
            size_ff <= HSIZE_IN;
         end
      end
   end

   reg [1:0] lane_ff;

   // Byte lane of the pending access
   always @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN) begin
         lane_ff <= 2'h0;
      end else if (HREADY_IN) begin
         lane_ff <= HADDR_IN[1:0];
      end
   end

   // Narrow data sits in lane 0; other lanes are reserved
   assign low_lane = (lane_ff == 2'h0);
   assign wbyte    = HWDATA_IN[7:0];
   assign hiz_ok   = low_lane & (size_ff != `PWO_HSIZE_HALF);

   // ------------------------------------------------------------------------
   // Pin configuration and timer control registers
   // ------------------------------------------------------------------------

   reg  [7:0] upper_cfg_ff;
   reg  [7:0] lower_cfg_ff;
   reg  [7:0] timer_ctl_ff;
   wire       wr_upper;
   wire       wr_lower;
   wire       wr_timer;
   wire       count_en;

   assign wr_upper = wr_ff & low_lane & (addr_ff == `PWO_ADDR_UPPER_CFG);
   assign wr_lower = wr_ff & low_lane & (addr_ff == `PWO_ADDR_LOWER_CFG);
   assign wr_timer = wr_ff & low_lane & (addr_ff == `PWO_ADDR_TIMER_CTL);
   assign count_en = timer_ctl_ff[`PWO_TCTL_CE];

   // Config registers; lower one refuses changes while counting
   always @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN) begin
         upper_cfg_ff <= `PWO_RST_UPPER_CFG;
         lower_cfg_ff <= `PWO_RST_LOWER_CFG;
         timer_ctl_ff <= `PWO_RST_TIMER_CTL;
      end else begin
         if (wr_upper) begin
            upper_cfg_ff <= wbyte & `PWO_CFG_USED_MASK;
         end
         if (wr_lower && !count_en) begin
            lower_cfg_ff <= wbyte & `PWO_CFG_USED_MASK;
         end
         if (wr_timer) begin
            timer_ctl_ff <= wbyte & `PWO_TCTL_MASK;
         end
      end
   end

   // ------------------------------------------------------------------------
   // High-impedance control groups
   // ------------------------------------------------------------------------

   wire [7:0] hiz_ctrl_group0_a;
   wire [7:0] hiz_ctrl_group0_b;
   wire [7:0] hiz_ctrl_group1_a;
   wire [7:0] hiz_ctrl_group1_b;
   wire [3:0] hiz_req;
   wire [3:0] hiz_wr;
   wire [3:0] func_sel;

   // Pin function selects: bit 4 phase pins, 5 aux, 6 timer2, 7 timer3
   assign func_sel = timer_ctl_ff[`PWO_TCTL_FUNC_LO + 3:`PWO_TCTL_FUNC_LO];

   assign hiz_wr[0] = wr_ff & hiz_ok & (addr_ff == `PWO_ADDR_HIZ_G0A);
   assign hiz_wr[1] = wr_ff & hiz_ok & (addr_ff == `PWO_ADDR_HIZ_G0B);
   assign hiz_wr[2] = wr_ff & hiz_ok & (addr_ff == `PWO_ADDR_HIZ_G1A);
   assign hiz_wr[3] = wr_ff & hiz_ok & (addr_ff == `PWO_ADDR_HIZ_G1B);

   // Group 0a: auxiliary timer outputs
   pwo_hiz u_hiz_g0a (
      .clk          (SYS_CLK_IN),
      .rst_n        (RSTN_IN),
      .wr_en        (hiz_wr[0]),
      .wdata        (wbyte),
      .ctrl         (hiz_ctrl_group0_a),
      .shutdown_pin (AUX_TIMER_SHUTDOWN_INPUT_IN),
      .func_sel     (func_sel[1]),
      .hiz          (hiz_req[0])
   );

   // Group 0b: timer 2 output
   pwo_hiz u_hiz_g0b (
      .clk          (SYS_CLK_IN),
      .rst_n        (RSTN_IN),
      .wr_en        (hiz_wr[1]),
      .wdata        (wbyte),
      .ctrl         (hiz_ctrl_group0_b),
      .shutdown_pin (TIMER2_SHUTDOWN_INPUT_IN),
      .func_sel     (func_sel[2]),
      .hiz          (hiz_req[1])
   );

   // Group 1a: all six phase pins
   pwo_hiz u_hiz_g1a (
      .clk          (SYS_CLK_IN),
      .rst_n        (RSTN_IN),
      .wr_en        (hiz_wr[2]),
      .wdata        (wbyte),
      .ctrl         (hiz_ctrl_group1_a),
      .shutdown_pin (PHASE_SHUTDOWN_INPUT_IN),
      .func_sel     (func_sel[0]),
      .hiz          (hiz_req[2])
   );

   // Group 1b: timer 3 output
   pwo_hiz u_hiz_g1b (
      .clk          (SYS_CLK_IN),
      .rst_n        (RSTN_IN),
      .wr_en        (hiz_wr[3]),
      .wdata        (wbyte),
      .ctrl         (hiz_ctrl_group1_b),
      .shutdown_pin (TIMER3_SHUTDOWN_INPUT_IN),
      .func_sel     (func_sel[3]),
      .hiz          (hiz_req[3])
   );

   // ------------------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------------------

   reg [CHANNELS-1:0] nxt_upper;
   reg [CHANNELS-1:0] nxt_lower;
   integer            m;

   // Per-channel level from the config bits and the waveform
   always @* begin
      nxt_upper = {CHANNELS{1'b0}};
      nxt_lower = {CHANNELS{1'b0}};
      for (m = 0; m < CHANNELS; m = m + 1) begin
         nxt_upper[m] = drive_level(cfg_bit(upper_cfg_ff, m, 1'b1),
                                    cfg_bit(upper_cfg_ff, m, 1'b0),
                                    count_en, PWM_UPPER_IN[m]);
         nxt_lower[m] = drive_level(cfg_bit(lower_cfg_ff, m, 1'b1),
                                    cfg_bit(lower_cfg_ff, m, 1'b0),
                                    count_en, PWM_LOWER_IN[m]);
      end
   end

   // Registered pins; phase group floats all six while its request holds
   always @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN) begin
         UPPER_PHASE_PIN_OUT     <= {CHANNELS{1'b0}};
         LOWER_PHASE_PIN_OUT     <= {CHANNELS{1'b1}};
         UPPER_PHASE_PIN_OEN_OUT <= {CHANNELS{1'b0}};
         LOWER_PHASE_PIN_OEN_OUT <= {CHANNELS{1'b0}};
         TIMER_COUNT_ENABLE_OUT  <= 1'b0;
         HIZ_GROUP_OUT           <= 4'h0;
      end else begin
         UPPER_PHASE_PIN_OUT     <= nxt_upper;
         LOWER_PHASE_PIN_OUT     <= nxt_lower;
         UPPER_PHASE_PIN_OEN_OUT <= {CHANNELS{hiz_req[2]}};
         LOWER_PHASE_PIN_OEN_OUT <= {CHANNELS{hiz_req[2]}};
         TIMER_COUNT_ENABLE_OUT  <= count_en;
         HIZ_GROUP_OUT           <= hiz_req;
      end
   end

   // ------------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------------

   reg [7:0] nxt_rbyte;

   // Register selected by the address phase; unmapped reads zero
   always @* begin
      case ({HADDR_IN[5:2], 2'b00})
         `PWO_ADDR_UPPER_CFG: nxt_rbyte = upper_cfg_ff;
         `PWO_ADDR_LOWER_CFG: nxt_rbyte = lower_cfg_ff;
         `PWO_ADDR_TIMER_CTL: nxt_rbyte = timer_ctl_ff;
         `PWO_ADDR_PIN_STAT:  nxt_rbyte = {HIZ_GROUP_OUT, 1'b0,
                                           UPPER_PHASE_PIN_OUT};
         `PWO_ADDR_HIZ_G0A:   nxt_rbyte = hiz_ctrl_group0_a;
         `PWO_ADDR_HIZ_G0B:   nxt_rbyte = hiz_ctrl_group0_b;
         `PWO_ADDR_HIZ_G1A:   nxt_rbyte = hiz_ctrl_group1_a;
         `PWO_ADDR_HIZ_G1B:   nxt_rbyte = hiz_ctrl_group1_b;
         default:             nxt_rbyte = 8'h00;
      endcase
   end

   // Read data valid in the data phase; upper bytes read zero
   always @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN) begin
         HRDATA_OUT <= 32'h0000_0000;
      end else if (addr_take && !HWRITE_IN && HADDR_IN[31:6] == 26'h0) begin
         HRDATA_OUT <= {24'h00_0000, nxt_rbyte};
      end else begin
         HRDATA_OUT <= 32'h0000_0000;
      end
   end

endmodule // pwo_top
`default_nettype wire

// ---- pwo_top_checker.sv ----
// Port-level assertions for the PWM pin output stage
`timescale 1ns/1ns
`default_nettype none
`include "pwo_regs.vh"
module pwo_top_checker #(
   parameter CHANNELS = 3
) (
   // Clock, reset and bus
   input  wire                SYS_CLK_IN,
   input  wire                RSTN_IN,
   input  wire                HSEL_IN,
   input  wire [1:0]          HTRANS_IN,
   input  wire                HWRITE_IN,
   input  wire                HREADY_IN,
   input  wire [31:0]         HRDATA_OUT,
   input  wire                HREADYOUT_OUT,
   input  wire                HRESP_OUT,
   // Waveforms and pins
   input  wire [CHANNELS-1:0] PWM_UPPER_IN,
   input  wire [CHANNELS-1:0] PWM_LOWER_IN,
   input  wire [CHANNELS-1:0] UPPER_PHASE_PIN_OUT,
   input  wire [CHANNELS-1:0] UPPER_PHASE_PIN_OEN_OUT,
   input  wire [CHANNELS-1:0] LOWER_PHASE_PIN_OUT,
   input  wire [CHANNELS-1:0] LOWER_PHASE_PIN_OEN_OUT,
   input  wire [3:0]          HIZ_GROUP_OUT
);
   // Transfers accepted in an address phase
   wire take    = HSEL_IN && HREADY_IN && (HTRANS_IN == `PWO_HTRANS_NONSEQ);
   wire wr_take = take && HWRITE_IN;
   wire rd_take = take && !HWRITE_IN;

   property p_ready;
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN) take |=> HREADYOUT_OUT;
   endproperty
   a_ready: assert property (p_ready) else $error("hreadyout low");
   property p_okay;
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN) take |=> !HRESP_OUT [*2];
   endproperty
   a_okay: assert property (p_okay) else $error("hresp not okay");
   property p_rst_pins;
      @(posedge SYS_CLK_IN) !RSTN_IN |=> UPPER_PHASE_PIN_OUT == 0
         && (&LOWER_PHASE_PIN_OUT) && UPPER_PHASE_PIN_OEN_OUT == 0 && LOWER_PHASE_PIN_OEN_OUT == 0;
   endproperty
   a_rst_pins: assert property (p_rst_pins) else $error("pins not at reset level");
   property p_rst_hiz;
      @(posedge SYS_CLK_IN) !RSTN_IN |=> HIZ_GROUP_OUT == 4'h0;
   endproperty
   a_rst_hiz: assert property (p_rst_hiz) else $error("hiz group set after reset");
   property p_rd_idle;
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN) !rd_take |=> HRDATA_OUT == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
   property p_rd_byte;
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN) rd_take |=> HRDATA_OUT[31:8] == 24'h0;
   endproperty
   a_rd_byte: assert property (p_rd_byte) else $error("upper read bytes not zero");
   property p_oen_pair;
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN) UPPER_PHASE_PIN_OEN_OUT == LOWER_PHASE_PIN_OEN_OUT
         && (UPPER_PHASE_PIN_OEN_OUT == 0 || (&UPPER_PHASE_PIN_OEN_OUT));
   endproperty
   a_oen_pair: assert property (p_oen_pair) else $error("phase pin enables split");
   property p_oen_hiz;
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN) (|UPPER_PHASE_PIN_OEN_OUT) |-> HIZ_GROUP_OUT[2];
   endproperty
   a_oen_hiz: assert property (p_oen_hiz) else $error("pins released without hiz");
   property p_pins_quiet;
      @(posedge SYS_CLK_IN) disable iff (!RSTN_IN) !wr_take ##1 !wr_take ##1 (!wr_take
         && $stable(PWM_UPPER_IN) && $stable(PWM_LOWER_IN))
         |=> $stable({UPPER_PHASE_PIN_OUT, LOWER_PHASE_PIN_OUT});
   endproperty
   a_pins_quiet: assert property (p_pins_quiet) else $error("pins moved without cause");
endmodule // pwo_top_checker
bind pwo_top pwo_top_checker #(.CHANNELS(CHANNELS)) pwo_top_checker_i (
   .SYS_CLK_IN(SYS_CLK_IN), .RSTN_IN(RSTN_IN), .HSEL_IN(HSEL_IN), .HTRANS_IN(HTRANS_IN),
   .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
   .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .PWM_UPPER_IN(PWM_UPPER_IN),
   .PWM_LOWER_IN(PWM_LOWER_IN), .UPPER_PHASE_PIN_OUT(UPPER_PHASE_PIN_OUT),
   .UPPER_PHASE_PIN_OEN_OUT(UPPER_PHASE_PIN_OEN_OUT), .LOWER_PHASE_PIN_OUT(LOWER_PHASE_PIN_OUT),
   .LOWER_PHASE_PIN_OEN_OUT(LOWER_PHASE_PIN_OEN_OUT), .HIZ_GROUP_OUT(HIZ_GROUP_OUT));
`default_nettype wire

// ---- pwo_top_tb.sv ----
// Self-checking bench for the PWM pin output stage
`timescale 1ns/1ns
`default_nettype none
`include "pwo_regs.vh"
module pwo_top_tb;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [2:0]  pwm_u = 3'h0;
   logic [2:0]  pwm_l = 3'h0;
   logic [3:0]  sd_cmd = 4'h0;
   logic [7:0]  cfg;
   logic [2:0]  eu;
   logic [2:0]  el;
   wire  [31:0] hrdata;
   wire         hready;
   wire  [2:0]  up, upn, lo, lon;
   wire  [3:0]  sd, hiz;
   wire  [5:0]  wl;
   wire         ce;
   int          mismatches = 0;
   int          checks = 0;

   // ------------------------------------------------------------------
   // Clock, block and gate drivers
   // ------------------------------------------------------------------
   always #25 clk = ~clk;
   pwo_top pwo_top_i (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
      .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(),
      .PWM_UPPER_IN(pwm_u), .PWM_LOWER_IN(pwm_l), .PHASE_SHUTDOWN_INPUT_IN(sd[2]),
      .AUX_TIMER_SHUTDOWN_INPUT_IN(sd[0]), .TIMER2_SHUTDOWN_INPUT_IN(sd[1]),
      .TIMER3_SHUTDOWN_INPUT_IN(sd[3]), .UPPER_PHASE_PIN_OUT(up), .UPPER_PHASE_PIN_OEN_OUT(upn),
      .LOWER_PHASE_PIN_OUT(lo), .LOWER_PHASE_PIN_OEN_OUT(lon), .TIMER_COUNT_ENABLE_OUT(ce),
      .HIZ_GROUP_OUT(hiz));
   pwo_gate_model pwo_gate_model_i (.clk_in(clk), .sd_cmd_in(sd_cmd), .pin_in({up, lo}),
      .oen_in({upn, lon}), .sd_out(sd), .wire_out(wl));

   // ------------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                       input logic [2:0] sz, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= `PWO_HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= sz;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz = 3'h2);
      logic [31:0] v;
      xfer(a, 1'b1, d, sz, v);
   endtask
   task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] v;
      xfer(a, 1'b0, 32'h0, 3'h2, v);
      chk(nm, exp, v);
   endtask
   task automatic settle();
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic end_of_test();
      if (mismatches == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      chk("reset_pins", 32'h1c0, {lo, up, upn | lon});
      rd("upper_cfg", `PWO_ADDR_UPPER_CFG, 32'h00);
      rd("lower_cfg", `PWO_ADDR_LOWER_CFG, 32'ha8);
      rd("timer_ctl", `PWO_ADDR_TIMER_CTL, 32'h00);
      for (int g = 0; g < 4; g++) rd("hiz_reset", `PWO_ADDR_HIZ_G0A + 4 * g, 32'h0);
      rd("unmapped", 32'h40, 32'h0);
      wr(32'h40, 32'hfc);
      rd("unmapped_wr", `PWO_ADDR_UPPER_CFG, 32'h00);
      // Every level, enable and count-enable setting with two waveforms
      for (int i = 0; i < 8; i++) begin
         cfg = (i[2] ? 8'ha8 : 8'h00) | (i[1] ? 8'h54 : 8'h00);
         wr(`PWO_ADDR_TIMER_CTL, 32'h0);
         wr(`PWO_ADDR_UPPER_CFG, {24'h0, cfg});
         wr(`PWO_ADDR_LOWER_CFG, {24'h0, cfg});
         wr(`PWO_ADDR_TIMER_CTL, {31'h0, i[0]});
         for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            pwm_u <= p ? 3'h5 : 3'h2;
            pwm_l <= p ? 3'h3 : 3'h4;
            settle();
            eu = (i[1] & i[0]) ? pwm_u ^ {3{i[2]}} : {3{i[2]}};
            el = (i[1] & i[0]) ? pwm_l ^ {3{i[2]}} : {3{i[2]}};
            chk("upper_pins", eu, wl[5:3]);
            chk("lower_pins", el, wl[2:0]);
            chk("count_enable", i[0], ce);
         end
      end
      // Lower configuration is locked while counting
      wr(`PWO_ADDR_LOWER_CFG, 32'h00);
      rd("lower_lock", `PWO_ADDR_LOWER_CFG, 32'hfc);
      wr(`PWO_ADDR_TIMER_CTL, 32'h0);
      // Detect flag, trigger, clear and access sizes
      wr(`PWO_ADDR_HIZ_G0B, 32'h90);
      wr(`PWO_ADDR_HIZ_G0B, 32'h98);
      rd("hiz_trigger", `PWO_ADDR_HIZ_G0B, 32'h91);
      wr(`PWO_ADDR_HIZ_G0B, 32'h90);
      rd("hiz_same", `PWO_ADDR_HIZ_G0B, 32'h91);
      wr(`PWO_ADDR_HIZ_G0B, 32'h94, `PWO_HSIZE_HALF);
      rd("hiz_half", `PWO_ADDR_HIZ_G0B, 32'h91);
      wr(`PWO_ADDR_HIZ_G0B, 32'h94, 3'h0);
      rd("hiz_clear", `PWO_ADDR_HIZ_G0B, 32'h90);
      wr(`PWO_ADDR_HIZ_G0B, 32'h91);
      rd("hiz_flag_ro", `PWO_ADDR_HIZ_G0B, 32'h90);
      wr(`PWO_ADDR_HIZ_G0B, 32'h00);
      // Each shutdown pin releases only its own group
      wr(`PWO_ADDR_TIMER_CTL, 32'hf0);
      for (int g = 0; g < 4; g++) begin
         wr(`PWO_ADDR_HIZ_G0A + 4 * g, 32'h90);
         sd_cmd <= 4'h1 << g;
         repeat (5) @(posedge clk);
         @(negedge clk);
         chk("hiz_group", 32'h1 << g, hiz);
         chk("pin_oen", (g == 2) ? 32'h3f : 32'h0, {upn, lon});
         rd("hiz_flag", `PWO_ADDR_HIZ_G0A + 4 * g, 32'h91);
         sd_cmd <= 4'h0;
         wr(`PWO_ADDR_HIZ_G0A + 4 * g, 32'h00);
         settle();
         chk("hiz_off", 32'h0, {hiz, upn, lon});
      end
      // Low-active pin with clear mode: clear refused while pin active
      wr(`PWO_ADDR_HIZ_G0A, 32'hc0);
      rd("hiz_low_act", `PWO_ADDR_HIZ_G0A, 32'hc1);
      wr(`PWO_ADDR_HIZ_G0A, 32'hc4);
      rd("hiz_mode_clr", `PWO_ADDR_HIZ_G0A, 32'hc1);
      wr(`PWO_ADDR_HIZ_G0A, 32'h00);
      // No release while the pins are not in timer function
      wr(`PWO_ADDR_TIMER_CTL, 32'h00);
      wr(`PWO_ADDR_HIZ_G1A, 32'h90);
      sd_cmd <= 4'h4;
      repeat (5) @(posedge clk);
      @(negedge clk);
      chk("oen_no_func", 32'h0, {upn, lon});
      @(posedge clk);
      sd_cmd <= 4'h0;
      wr(`PWO_ADDR_HIZ_G1A, 32'h00);
      settle();
      rd("pin_status", `PWO_ADDR_PIN_STAT, 32'h07);
      end_of_test();
   end

   // Watchdog against a hung transfer
   initial begin
      #2000000;
      mismatches++;
      end_of_test();
   end
endmodule // pwo_top_tb
`default_nettype wire
